// ### hdl/ptm_core.sv
// periodic timer core: 10-bit counter, compare A/P, capture, pwm and register port
`timescale 1ns/10ps
module ptm_core
    import ptm_pkg::*;
(
    input  wire logic            core_clk_i,
    input  wire logic            rst_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [7:0]      wdata_i,
    input  wire logic            wr_i,
    input  wire logic            rd_i,
    output logic [7:0]           rdata_o,
    input  wire logic            high_clk_en_i,
    input  wire logic            sub_clk_en_i,
    input  wire logic            external_clock_pin_i,
    input  wire logic            capture_input_pin_i,
    output logic                 timer_output_pin_o,
    output logic                 timer_output_pin_n_o,
    output logic                 timer_irq_o
);
    ptm_state_type   s_q;
    ptm_state_type   s_d;
    ptm_bus_req_type req;
    logic            tick;
    logic            run_rise;
    logic            match_a;
    logic            match_p;
    logic            ovf;
    logic            clr;
    logic            ck_rise;
    logic            ck_fall;
    logic            trig_now;
    logic            trig_prev;
    logic            cap_ev;
    logic            req_lvl;
    logic            act;
    logic            pin_lvl;
    logic [7:0]      wr_c0;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    assign wr_c0 = req.wdata & CTRL0_MASK;

    // clock-source enable pulses; pin edges come from the synchronised copies only
    assign ck_rise = s_q.ck_sync[1] & ~s_q.ck_prev;
    assign ck_fall = ~s_q.ck_sync[1] & s_q.ck_prev;

    always_comb begin
        unique case (s_q.c0.clock_source_select)
            PTM_CK_SYS4: tick = (s_q.sdiv == 2'(SYS_DIV - 1));
            PTM_CK_SYS:  tick = 1'b1;
            PTM_CK_H16:  tick = high_clk_en_i && (s_q.pdiv[3:0] == 4'(HI_DIV16 - 1));
            PTM_CK_H64:  tick = high_clk_en_i && (s_q.pdiv == 6'(HI_DIV64 - 1));
            PTM_CK_SUB0,
            PTM_CK_SUB1: tick = sub_clk_en_i;
            PTM_CK_EXTR: tick = ck_rise;
            PTM_CK_EXTF: tick = ck_fall;
        endcase
    end

    assign run_rise = req.wr && (req.addr == OFF_CTRL0) && wr_c0[RUN_BIT]
                      && !s_q.c0.timer_run;
    assign match_a = (s_q.cnt == s_q.cmpa);
    assign match_p = (s_q.cnt == s_q.cmpp);
    assign act     = tick && s_q.c0.timer_run && !s_q.c0.counter_pause;
    assign ovf     = act && (s_q.cnt == '1) && (s_q.cmpp == '0);

    // clear events: capture and pwm always use P, compare/timer follow clear select
    always_comb begin
        if (s_q.c1.operating_mode_select == PTM_MODE_CMP
            || s_q.c1.operating_mode_select == PTM_MODE_TMR) begin
            clr = s_q.c1.counter_clear_select ? (act && match_a)
                                              : (act && match_p && s_q.cmpp != '0);
        end else begin
            clr = act && match_p && s_q.cmpp != '0;
        end
    end

    // capture trigger source and edge
    assign trig_now  = s_q.c1.capture_source_select ? s_q.ck_sync[1] : s_q.cap_sync[1];
    assign trig_prev = s_q.c1.capture_source_select ? s_q.ck_prev : s_q.cap_prev;
    always_comb begin
        unique case (s_q.c1.pin_function_select)
            2'b00:   cap_ev = trig_now & ~trig_prev;
            2'b01:   cap_ev = ~trig_now & trig_prev;
            2'b10:   cap_ev = trig_now ^ trig_prev;
            default: cap_ev = 1'b0;
        endcase
    end

    // compare-mode target level for an A match
    always_comb begin
        unique case (s_q.c1.pin_function_select)
            2'b00:   req_lvl = s_q.out;
            2'b01:   req_lvl = 1'b0;
            2'b10:   req_lvl = 1'b1;
            default: req_lvl = ~s_q.out;
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.rdata = '0;
        s_d.irq = 1'b0;
        s_d.ck_sync  = {s_q.ck_sync[0], external_clock_pin_i};
        s_d.cap_sync = {s_q.cap_sync[0], capture_input_pin_i};
        s_d.ck_prev  = s_q.ck_sync[1];
        s_d.cap_prev = s_q.cap_sync[1];
        s_d.sdiv = s_q.sdiv + 2'd1;
        if (high_clk_en_i) begin
            s_d.pdiv = s_q.pdiv + 6'd1;
        end

        // counting
        if (act) begin
            if (clr || ovf) begin
                s_d.cnt = '0;
            end else begin
                s_d.cnt = s_q.cnt + 10'd1;
            end
        end
        if (act && (match_a || match_p || ovf)
            && s_q.c1.operating_mode_select != PTM_MODE_CAP) begin
            s_d.irq = 1'b1;
        end

        // output behaviour per mode
        unique case (s_q.c1.operating_mode_select)
            PTM_MODE_CMP: begin
                if (act && match_a) begin
                    s_d.out = req_lvl;
                end
            end
            PTM_MODE_CAP: begin
                if (s_q.c0.timer_run && cap_ev) begin
                    s_d.cmpa = s_q.cnt;
                    s_d.irq  = 1'b1;
                end
                if (act && match_p && s_q.cmpp != '0) begin
                    s_d.irq = 1'b1;
                end
            end
            PTM_MODE_PWM: begin
                unique case (s_q.c1.pin_function_select)
                    2'b00: s_d.out = ~s_q.c1.output_initial_level;
                    2'b01: s_d.out = s_q.c1.output_initial_level;
                    2'b10: begin
                        if (act && clr) begin
                            s_d.out = s_q.c1.output_initial_level;
                        end else if (act && match_a) begin
                            s_d.out = ~s_q.c1.output_initial_level;
                        end
                    end
                    default: begin
                        // single pulse: active while running, A match ends it
                        if (act && match_a) begin
                            s_d.out = ~s_q.c1.output_initial_level;
                            s_d.c0.timer_run = 1'b0;
                        end
                    end
                endcase
            end
            default: ;
        endcase

        // register writes
        if (req.wr) begin
            unique case (req.addr)
                OFF_CTRL0: s_d.c0 = ptm_ctrl0_type'(wr_c0[7:3]);
                OFF_CTRL1: s_d.c1 = ptm_ctrl1_type'(req.wdata);
                OFF_CMPA_LO: s_d.cmpa[7:0] = req.wdata;
                OFF_CMPA_HI: s_d.cmpa[9:8] = req.wdata[1:0];
                OFF_CMPP_LO: s_d.cmpp[7:0] = req.wdata;
                OFF_CMPP_HI: s_d.cmpp[9:8] = req.wdata[1:0];
                default: ; // counter bytes are read-only
            endcase
        end
        if (run_rise) begin
            s_d.cnt = '0;
            // forced pwm levels are not restart levels, so they keep the pin
            if (s_d.c1.operating_mode_select == PTM_MODE_CMP
                || (s_d.c1.operating_mode_select == PTM_MODE_PWM
                    && s_d.c1.pin_function_select[1])) begin
                s_d.out = s_d.c1.output_initial_level;
            end
        end

        // read data one cycle after the strobe
        if (req.rd) begin
            unique case (req.addr)
                OFF_CTRL0:   s_d.rdata = {s_q.c0, 3'b000};
                OFF_CTRL1:   s_d.rdata = s_q.c1;
                OFF_CNT_LO:  s_d.rdata = s_q.cnt[7:0];
                OFF_CNT_HI:  s_d.rdata = {6'h00, s_q.cnt[9:8]};
                OFF_CMPA_LO: s_d.rdata = s_q.cmpa[7:0];
                OFF_CMPA_HI: s_d.rdata = {6'h00, s_q.cmpa[9:8]};
                OFF_CMPP_LO: s_d.rdata = s_q.cmpp[7:0];
                OFF_CMPP_HI: s_d.rdata = {6'h00, s_q.cmpp[9:8]};
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // polarity ignored in timer mode, where the pin simply rests low
    assign pin_lvl = (s_q.c1.operating_mode_select == PTM_MODE_TMR) ? 1'b0
                     : (s_q.out ^ s_q.c1.output_polarity);
    assign timer_output_pin_o   = pin_lvl;
    assign timer_output_pin_n_o = ~pin_lvl;
    assign rdata_o              = s_q.rdata;
    assign timer_irq_o          = s_q.irq;

    cnt_clear_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        run_rise |=> s_q.cnt == '0)
        else $error("counter not cleared by run rise");
    pause_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (s_q.c0.counter_pause && !run_rise) |=> $stable(s_q.cnt))
        else $error("counter moved while paused");
    off_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!s_q.c0.timer_run && !run_rise) |=> $stable(s_q.cnt))
        else $error("counter moved while off");
    ctrl0_low_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (req.rd && req.addr == OFF_CTRL0) |=> rdata_o[2:0] == 3'b000)
        else $error("ctrl0 low bits not zero");
    cnt_read_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (req.rd && req.addr == OFF_CNT_LO) |=> rdata_o == $past(s_q.cnt[7:0]))
        else $error("counter low byte read wrong");
    match_irq_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (act && match_a && s_q.c1.operating_mode_select == PTM_MODE_CMP)
        |=> timer_irq_o)
        else $error("no interrupt on match");
    clr_a_zero_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (act && match_a && s_q.c1.counter_clear_select && !req.wr
         && s_q.c1.operating_mode_select == PTM_MODE_CMP) |=> s_q.cnt == '0)
        else $error("A match did not clear counter");
    set_high_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (act && match_a && s_q.c1.operating_mode_select == PTM_MODE_CMP
         && s_q.c1.pin_function_select == 2'b10 && !req.wr) |=> s_q.out)
        else $error("output not driven high on match");
    sys_tick_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (s_q.c0.clock_source_select == PTM_CK_SYS && s_q.c0.timer_run
         && !s_q.c0.counter_pause && !clr && !ovf && !req.wr)
        |=> s_q.cnt == $past(s_q.cnt) + 10'd1)
        else $error("counter did not advance on system clock");
    clr_p_zero_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (act && match_p && s_q.cmpp != '0 && !s_q.c1.counter_clear_select)
        |=> s_q.cnt == '0)
        else $error("P match did not clear counter");
    toggle_out_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (act && match_a && s_q.c1.operating_mode_select == PTM_MODE_CMP
         && s_q.c1.pin_function_select == 2'b11) |=> s_q.out != $past(s_q.out))
        else $error("output did not toggle on match");
    run_restart_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (run_rise && s_q.c1.operating_mode_select == PTM_MODE_CMP)
        |=> s_q.out == s_q.c1.output_initial_level)
        else $error("run rise did not restore initial level");
    forced_pwm_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (s_q.c1.operating_mode_select == PTM_MODE_PWM && !s_q.c1.pin_function_select[1]
         && !req.wr)
        |=> s_q.out == (s_q.c1.output_initial_level ~^ s_q.c1.pin_function_select[0]))
        else $error("forced pwm level wrong");
    pulse_end_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (act && match_a && s_q.c1.operating_mode_select == PTM_MODE_PWM
         && s_q.c1.pin_function_select == 2'b11 && !req.wr)
        |=> !s_q.c0.timer_run && s_q.out != s_q.c1.output_initial_level)
        else $error("single pulse did not end on match");
    cap_store_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (s_q.c1.operating_mode_select == PTM_MODE_CAP && s_q.c0.timer_run && cap_ev
         && !req.wr) |=> s_q.cmpa == $past(s_q.cnt))
        else $error("capture did not store the count");
    cap_off_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (s_q.c1.operating_mode_select == PTM_MODE_CAP && s_q.c1.pin_function_select == 2'b11
         && !req.wr) |=> $stable(s_q.cmpa))
        else $error("capture taken while disabled");
    rdata_idle_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !req.rd |=> rdata_o == 8'h00)
        else $error("read data not idle");
endmodule : ptm_core

// ### hdl/ptm_pkg.sv
// package: register map, fields and types of the periodic timer core
package ptm_pkg;
    localparam int unsigned ADDR_W = 3;
    localparam logic [2:0] OFF_CTRL0   = 3'h0;
    localparam logic [2:0] OFF_CTRL1   = 3'h1;
    localparam logic [2:0] OFF_CNT_LO  = 3'h2;
    localparam logic [2:0] OFF_CNT_HI  = 3'h3;
    localparam logic [2:0] OFF_CMPA_LO = 3'h4;
    localparam logic [2:0] OFF_CMPA_HI = 3'h5;
    localparam logic [2:0] OFF_CMPP_LO = 3'h6;
    localparam logic [2:0] OFF_CMPP_HI = 3'h7;
    localparam logic [7:0] CTRL0_RESET = 8'h00;
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [7:0] CTRL0_MASK  = 8'hf8;
    localparam int unsigned PAUSE_BIT  = 7;
    localparam int unsigned RUN_BIT    = 3;
    localparam int unsigned CNT_W      = 10;
    localparam int unsigned SYS_DIV    = 4;
    localparam int unsigned HI_DIV16   = 16;
    localparam int unsigned HI_DIV64   = 64;

    typedef enum logic [1:0] {
        PTM_MODE_CMP  = 2'b00,
        PTM_MODE_CAP  = 2'b01,
        PTM_MODE_PWM  = 2'b10,
        PTM_MODE_TMR  = 2'b11
    } ptm_mode_type;

    typedef enum logic [2:0] {
        PTM_CK_SYS4 = 3'b000,
        PTM_CK_SYS  = 3'b001,
        PTM_CK_H16  = 3'b010,
        PTM_CK_H64  = 3'b011,
        PTM_CK_SUB0 = 3'b100,
        PTM_CK_SUB1 = 3'b101,
        PTM_CK_EXTR = 3'b110,
        PTM_CK_EXTF = 3'b111
    } ptm_clk_type;

    typedef struct packed {
        logic        counter_pause;
        ptm_clk_type clock_source_select;
        logic        timer_run;
    } ptm_ctrl0_type;

    typedef struct packed {
        ptm_mode_type operating_mode_select;
        logic [1:0]   pin_function_select;
        logic         output_initial_level;
        logic         output_polarity;
        logic         capture_source_select;
        logic         counter_clear_select;
    } ptm_ctrl1_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
        logic              wr;
        logic              rd;
    } ptm_bus_req_type;

    typedef struct packed {
        ptm_ctrl0_type   c0;
        ptm_ctrl1_type   c1;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] cmpa;
        logic [CNT_W-1:0] cmpp;
        logic [5:0]       pdiv;
        logic [1:0]       sdiv;
        logic             out;
        logic             irq;
        logic [7:0]       rdata;
        logic [1:0]       ck_sync;
        logic [1:0]       cap_sync;
        logic             ck_prev;
        logic             cap_prev;
    } ptm_state_type;
endpackage : ptm_pkg

// ### verif/ptm_pin_model.sv
// pin-side partner: external clock and capture pin pulses on command
`timescale 1ns/10ps
module ptm_pin_model (
    input  wire logic core_clk_i,
    input  wire logic ext_go_i,
    input  wire logic cap_go_i,
    output logic      external_clock_pin_o,
    output logic      capture_input_pin_o
);
    int ext_n = 0;
    int cap_n = 0;
    // pins idle low; four cycles high so the 2-ff synchroniser cannot miss an edge
    always @(posedge core_clk_i) begin
        ext_n <= ext_go_i ? 7 : (ext_n > 0 ? ext_n - 1 : 0);
        cap_n <= cap_go_i ? 7 : (cap_n > 0 ? cap_n - 1 : 0);
        external_clock_pin_o <= ext_go_i || ext_n > 4;
        capture_input_pin_o  <= cap_go_i || cap_n > 4;
    end
    initial begin
        external_clock_pin_o = 1'b0;
        capture_input_pin_o  = 1'b0;
    end
endmodule : ptm_pin_model

// ### verif/tb_top.sv
// self-checking bench: register port, clock sources, compare, pwm and capture
`timescale 1ns/10ps
module tb_top;
    import ptm_pkg::*;
    logic       clk, rst, wr, rd, hen, sen, ext_go, cap_go;
    logic       ck_pin, cap_pin, pin, pin_n, irq, lvl;
    logic [2:0] addr, sdiv;
    logic [7:0] wdata, rdata, rv;
    logic [7:0] regm [8];
    logic [9:0] v, v2;
    logic [3:0] kb;
    int         n_mismatch = 0;
    int         cmp_count = 0;
    int         irq_seen = 0;
    int         i0;
    int         per [6] = '{4, 1, 32, 128, 8, 8};

    ptm_core dut (
        .core_clk_i           (clk),
        .rst_i                (rst),
        .addr_i               (addr),
        .wdata_i              (wdata),
        .wr_i                 (wr),
        .rd_i                 (rd),
        .rdata_o              (rdata),
        .high_clk_en_i        (hen),
        .sub_clk_en_i         (sen),
        .external_clock_pin_i (ck_pin),
        .capture_input_pin_i  (cap_pin),
        .timer_output_pin_o   (pin),
        .timer_output_pin_n_o (pin_n),
        .timer_irq_o          (irq)
    );
    ptm_pin_model pins (
        .core_clk_i           (clk),
        .ext_go_i             (ext_go),
        .cap_go_i             (cap_go),
        .external_clock_pin_o (ck_pin),
        .capture_input_pin_o  (cap_pin)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // high enable every 2nd cycle, sub enable every 8th
    always @(posedge clk) begin
        hen  <= ~hen;
        sdiv <= sdiv + 3'h1;
        sen  <= (sdiv == 3'h7);
        if (irq === 1'b1) irq_seen <= irq_seen + 1;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [7:0] msk(input logic [2:0] a);
        if (a == OFF_CTRL0) return CTRL0_MASK;
        if (a == OFF_CNT_LO || a == OFF_CNT_HI) return 8'h00;
        return (a[0] && a != OFF_CTRL1) ? 8'h03 : 8'hff;
    endfunction : msk
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        regm[a] = d & msk(a);
    endtask : wr_reg
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg
    task automatic wr10(input logic [2:0] a, input logic [9:0] d);
        wr_reg(a, d[7:0]);
        wr_reg(a + 3'h1, {6'h00, d[9:8]});
    endtask : wr10
    // no byte latching: only used while the counter cannot cross a byte boundary
    task automatic rd10(input logic [2:0] a, output logic [9:0] d);
        logic [7:0] lo;
        logic [7:0] hi;
        rd_reg(a, lo);
        rd_reg(a + 3'h1, hi);
        d = {hi[1:0], lo};
    endtask : rd10
    task automatic start(input logic [7:0] c1, input logic [2:0] ck);
        wr_reg(OFF_CTRL0, {1'b0, ck, 4'h0});
        wr_reg(OFF_CTRL1, c1);
        wr_reg(OFF_CTRL0, {1'b0, ck, 4'h8});
    endtask : start
    task automatic pulse(input logic cap, input int n);
        repeat (n) begin
            @(posedge clk);
            if (cap) cap_go <= 1'b1;
            else ext_go <= 1'b1;
            @(posedge clk);
            ext_go <= 1'b0;
            cap_go <= 1'b0;
            repeat (10) @(posedge clk);
        end
    endtask : pulse
    task automatic pin_is(input logic e);
        #1;
        check(16'({pin, pin_n}), 16'({e, ~e}));
    endtask : pin_is
    task automatic stop_test();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    initial begin
        {rst, wr, rd, hen, sen, ext_go, cap_go} = 7'h40;
        {addr, wdata, sdiv} = '0;
        for (int i = 0; i < 8; i++) regm[i] = 8'h00;
        void'($urandom(32'h98231682));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd_reg(i[2:0], rv);
            check(16'(rv), 16'h0);
        end
        for (int i = 0; i < 8; i++) begin
            rv = 8'($urandom);
            if (i == 0) rv = (rv | 8'h07) & 8'hf7;
            wr_reg(i[2:0], rv);
            rd_reg(i[2:0], rv);
            check(16'(rv), 16'(regm[i]));
        end
        wr10(OFF_CMPP_LO, 10'h000);
        for (int s = 0; s < 6; s++) begin
            start(8'hc0, s[2:0]);
            repeat (254) @(posedge clk);
            wr_reg(OFF_CTRL0, {1'b1, s[2:0], 4'h8});
            rd10(OFF_CNT_LO, v);
            check(16'(v + 3 >= 256 / per[s] && v <= 256 / per[s] + 3), 16'h1);
            repeat (16) @(posedge clk);
            rd10(OFF_CNT_LO, v2);
            check(16'(v2), 16'(v));
        end
        wr_reg(OFF_CTRL0, 8'h18);
        repeat (10) @(posedge clk);
        wr_reg(OFF_CTRL0, 8'h98);
        rd10(OFF_CNT_LO, v2);
        check(16'(v2 > v && v2 < v + 20), 16'h1);
        wr_reg(OFF_CTRL0, 8'h10);
        rd10(OFF_CNT_LO, v);
        repeat (16) @(posedge clk);
        rd10(OFF_CNT_LO, v2);
        check(16'(v2), 16'(v));
        wr_reg(OFF_CTRL0, 8'h18);
        rd10(OFF_CNT_LO, v);
        check(16'(v < 10), 16'h1);
        for (int s = 6; s < 8; s++) begin
            start(8'hc0, s[2:0]);
            pulse(1'b0, 5);
            wr_reg(OFF_CTRL0, {1'b1, s[2:0], 4'h8});
            pulse(1'b0, 2);
            rd10(OFF_CNT_LO, v);
            check(16'(v), 16'd5);
        end
        for (int j = 0; j < 2; j++) begin
            wr10(OFF_CMPA_LO, 10'd15);
            wr10(OFF_CMPP_LO, 10'd20);
            start(8'hc0 | 8'(j), 3'h1);
            for (int n = 0; n < 30; n++) begin
                rd_reg(OFF_CNT_LO, rv);
                check(16'(rv <= (j ? 15 : 20)), 16'h1);
            end
        end
        wr10(OFF_CMPA_LO, 10'd3);
        wr10(OFF_CMPP_LO, 10'h200);
        for (int k = 0; k < 16; k++) begin
            kb = 4'(k);
            start({2'b00, kb[1:0], kb[2], kb[3], 2'b01}, 3'h6);
            pin_is(kb[2] ^ kb[3]);
            i0 = irq_seen;
            // the match acts on the edge taken while the counter sits at 3
            pulse(1'b0, 4);
            lvl = kb[1:0] == 2'b00 ? kb[2] : (kb[1:0] == 2'b11 ? ~kb[2] : kb[1]);
            pin_is(lvl ^ kb[3]);
            check(16'(irq_seen - i0), 16'h1);
        end
        for (int k = 0; k < 8; k++) begin
            kb = 4'(k);
            start({2'b10, 1'b0, kb[0], kb[1], kb[2], 2'b00}, 3'h6);
            pin_is((kb[0] ? kb[1] : ~kb[1]) ^ kb[2]);
        end
        // pwm waveform then single pulse: A at 2, P at 5, active high
        wr10(OFF_CMPA_LO, 10'd2);
        wr10(OFF_CMPP_LO, 10'd5);
        for (int k = 2; k < 4; k++) begin
            start({2'b10, 2'(k), 4'h8}, 3'h6);
            pin_is(1'b1);
            pulse(1'b0, 3);
            pin_is(1'b0);
            pulse(1'b0, 3);
            pin_is(k == 2);
            rd_reg(OFF_CTRL0, rv);
            check(16'(rv[RUN_BIT]), 16'(k == 2));
        end
        start(8'hc4, 3'h1);
        pin_is(1'b0);
        wr10(OFF_CMPP_LO, 10'h000);
        // k == 4 selects the clock pin as trigger while only the capture pin moves
        for (int k = 0; k < 5; k++) begin
            kb = 4'(k);
            wr10(OFF_CMPA_LO, 10'h000);
            start({2'b01, kb[1:0], 2'b00, kb[2], 1'b0}, 3'h1);
            repeat (20) @(posedge clk);
            pulse(1'b1, 1);
            rd10(OFF_CMPA_LO, v);
            check(16'(v != 0), 16'(k < 3));
        end
        stop_test();
    end
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end
endmodule : tb_top
